// [hdl/sdos_top.sv]
// start signal decode and output terminal function selection
`timescale 1ns/1ns
module sdos_top
  import sdos_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES,
  parameter int unsigned P_DATA_W = 16,
  parameter logic [7:0] P_THERM_PRE_PCT = THERM_PRE_PCT
)(
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_FWD_START_IN,
  input wire logic I_REV_START_IN,
  input wire logic [SEL_W-1:0] I_STOP_SELECT_SETTING,
  input wire logic I_POS_CTRL,
  input wire logic I_SELF_HOLD_REQ,
  input wire logic [SEL_W-1:0] I_OUT0_FUNC_SELECT,
  input wire logic I_OUT0_SEL_WR,
  input wire logic [SEL_W-1:0] I_OUT1_FUNC_SELECT,
  input wire logic I_OUT1_SEL_WR,
  input wire logic [SEL_W-1:0] I_RELAY_FUNC_SELECT,
  input wire logic I_RELAY_SEL_WR,
  input wire logic I_INIT_DONE,
  input wire logic I_START_BEGIN,
  input wire logic I_DECEL_STOP,
  input wire logic I_ZERO_SPEED,
  input wire logic I_SERVO_LOCK,
  input wire logic I_OP_READY2,
  input wire logic I_SPEED_REACHED,
  input wire logic I_TORQUE_LIMIT,
  input wire logic [P_DATA_W-1:0] I_SPEED,
  input wire logic I_REV_ROT,
  input wire logic [P_DATA_W-1:0] I_FWD_THRESH,
  input wire logic [P_DATA_W-1:0] I_REV_THRESH,
  input wire logic [7:0] I_REGEN_DUTY,
  input wire logic [7:0] I_REGEN_LIMIT,
  input wire logic [7:0] I_THERMAL_PCT,
  input wire logic [P_DATA_W-1:0] I_CUR,
  input wire logic [P_DATA_W-1:0] I_CUR_LEVEL,
  input wire logic [CNT_W-1:0] I_CUR_TIME_MS,
  input wire logic [P_DATA_W-1:0] I_ZERO_LEVEL,
  input wire logic [CNT_W-1:0] I_ZERO_TIME_MS,
  input wire logic I_FAULT,
  input wire logic I_AUX93,
  output logic [1:0] O_RUN_CMD,
  output logic O_COAST_STOP,
  output logic O_SELF_HOLD_EN,
  output logic O_THERMAL_TRIP,
  output logic O_OUT0,
  output logic O_OUT1,
  output logic O_RELAY_OUT,
  output logic [SEL_W-1:0] O_OUT0_FUNC_SELECT,
  output logic [SEL_W-1:0] O_OUT1_FUNC_SELECT,
  output logic [SEL_W-1:0] O_RELAY_FUNC_SELECT,
  output logic [2:0] O_SEL_REJECT
);

  sdos_top_st_t st;
  sdos_top_st_t next_st;
  sdos_status_t status;
  logic tick;
  logic [15:0] regen_lhs;
  logic [15:0] regen_rhs;
  logic [2:0] sel_wr;
  logic [SEL_W-1:0] sel_code [3];
  logic [SEL_W-1:0] sel_out [3];
  logic [2:0] term_level;

  // ****************************************
  // start decode, running flag and detectors
  // ****************************************
  always_comb begin
    next_st = st;
    status = '0;
    regen_lhs = 16'(I_REGEN_DUTY) * PCT_FULL;
    regen_rhs = 16'(I_REGEN_LIMIT) * REGEN_PRE_PCT;
    next_st.self_hold = I_SELF_HOLD_REQ & ~I_POS_CTRL;
    // stop setting outside both ranges and not STOP_DEC_TWO or STOP_DEC_DIR keeps the old mode
    if (I_STOP_SELECT_SETTING <= STOP_TIME_MAX ||
        I_STOP_SELECT_SETTING == STOP_DEC_TWO) begin
      next_st.stop_mode = SDOS_SM_TWO;
      next_st.coast = (I_STOP_SELECT_SETTING != STOP_DEC_TWO);
    end else if ((I_STOP_SELECT_SETTING >= STOP_DIR_MIN &&
                  I_STOP_SELECT_SETTING <= STOP_DIR_MAX) ||
                 I_STOP_SELECT_SETTING == STOP_DEC_DIR) begin
      next_st.stop_mode = SDOS_SM_DIR;
      next_st.coast = (I_STOP_SELECT_SETTING != STOP_DEC_DIR);
    end
    unique case (next_st.stop_mode)
      SDOS_SM_TWO: begin
        if (I_FWD_START_IN && !I_REV_START_IN) begin
          next_st.run_cmd = SDOS_RC_FWD;
        end else if (I_REV_START_IN && !I_FWD_START_IN) begin
          next_st.run_cmd = SDOS_RC_REV;
        end else begin
          next_st.run_cmd = SDOS_RC_STOP;
        end
      end
      SDOS_SM_DIR: begin
        if (I_FWD_START_IN && !I_REV_START_IN) begin
          next_st.run_cmd = SDOS_RC_FWD;
        end else if (I_FWD_START_IN && I_REV_START_IN) begin
          next_st.run_cmd = SDOS_RC_REV;
        end else begin
          next_st.run_cmd = SDOS_RC_STOP;
        end
      end
    endcase
    if (I_POS_CTRL) begin
      next_st.run_flag = I_OP_READY2;
    end else if (I_DECEL_STOP || I_ZERO_SPEED || I_SERVO_LOCK) begin
      next_st.run_flag = 1'b0;
    end else if (I_START_BEGIN && next_st.run_cmd != SDOS_RC_STOP) begin
      next_st.run_flag = 1'b1;
    end
    if (I_THERMAL_PCT >= THERM_TRIP_PCT) begin
      next_st.therm_trip = 1'b1;
    end
    // millisecond enable for the detection timers
    tick = (st.tick_cnt == TICK_W'(P_TICK_CYCLES - 1));
    next_st.tick_cnt = tick ? '0 : st.tick_cnt + 1'b1;
    if (I_CUR < I_CUR_LEVEL) begin
      next_st.cur_cnt = '0;
    end else if (tick && st.cur_cnt != '1) begin
      next_st.cur_cnt = st.cur_cnt + 1'b1;
    end
    if (I_CUR > I_ZERO_LEVEL) begin
      next_st.zero_cnt = '0;
    end else if (tick && st.zero_cnt != '1) begin
      next_st.zero_cnt = st.zero_cnt + 1'b1;
    end
    status.running = next_st.run_flag;
    status.up_to_speed = ~I_POS_CTRL & I_SPEED_REACHED;
    status.overload = I_TORQUE_LIMIT;
    status.speed_detect = I_REV_ROT ? (I_SPEED >= I_REV_THRESH) :
                          (I_SPEED >= I_FWD_THRESH);
    status.regen_pre = (I_REGEN_LIMIT != 8'h00) &&
                       (regen_lhs >= regen_rhs);
    status.thermal_pre = (I_THERMAL_PCT >= P_THERM_PRE_PCT);
    status.fault = I_FAULT | next_st.therm_trip;
    status.op_ready = (I_INIT_DONE & ~status.fault) |
                      next_st.run_flag;
    status.op_ready2 = I_OP_READY2;
    status.cur_detect = (st.cur_cnt > I_CUR_TIME_MS);
    status.zero_cur = (st.zero_cnt > I_ZERO_TIME_MS);
    status.oc_only = I_AUX93;
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign O_RUN_CMD = st.run_cmd;
  assign O_COAST_STOP = st.coast;
  assign O_SELF_HOLD_EN = st.self_hold;
  assign O_THERMAL_TRIP = st.therm_trip;

  // ****************************************
  // output terminals
  // ****************************************
  assign sel_wr = {I_RELAY_SEL_WR, I_OUT1_SEL_WR, I_OUT0_SEL_WR};
  assign sel_code[0] = I_OUT0_FUNC_SELECT;
  assign sel_code[1] = I_OUT1_FUNC_SELECT;
  assign sel_code[2] = I_RELAY_FUNC_SELECT;

  for (genvar g = 0; g < 3; g++) begin : g_term
    // two collector outputs then the relay
    sdos_term #(
      .P_INIT(g == 0 ? SEL_INIT_OC0 :
              g == 1 ? SEL_INIT_OC1 : SEL_INIT_RELAY),
      .P_RELAY(g == 2)
    ) u_term (
      .i_mclk(I_MCLK),
      .i_rst_n(I_RST_N),
      .i_wr(sel_wr[g]),
      .i_code(sel_code[g]),
      .i_status(status),
      .o_level(term_level[g]),
      .o_select(sel_out[g]),
      .o_reject(O_SEL_REJECT[g])
    );
  end

  assign O_OUT0 = term_level[0];
  assign O_OUT1 = term_level[1];
  assign O_RELAY_OUT = term_level[2];
  assign O_OUT0_FUNC_SELECT = sel_out[0];
  assign O_OUT1_FUNC_SELECT = sel_out[1];
  assign O_RELAY_FUNC_SELECT = sel_out[2];

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_oc0_hold(logic [SEL_W-1:0] code);
    O_OUT0_FUNC_SELECT == code && !I_OUT0_SEL_WR;
  endsequence

  sequence s_oc1_hold(logic [SEL_W-1:0] code);
    O_OUT1_FUNC_SELECT == code && !I_OUT1_SEL_WR;
  endsequence

  sequence s_two_wire;
    I_STOP_SELECT_SETTING == STOP_DEC_TWO;
  endsequence

  sequence s_dir_mode;
    I_STOP_SELECT_SETTING == STOP_DEC_DIR;
  endsequence

  self_hold_a: assert property (
    I_POS_CTRL |=> !O_SELF_HOLD_EN)
    else $error("self-holding enabled in position control");

  two_wire_fwd_a: assert property (
    s_two_wire ##0 (I_FWD_START_IN && !I_REV_START_IN)
    |=> O_RUN_CMD == SDOS_RC_FWD)
    else $error("two-wire forward start not decoded");

  two_wire_rev_a: assert property (
    s_two_wire ##0 (!I_FWD_START_IN && I_REV_START_IN)
    |=> O_RUN_CMD == SDOS_RC_REV)
    else $error("two-wire reverse start not decoded");

  two_wire_stop_a: assert property (
    s_two_wire ##0 (I_FWD_START_IN == I_REV_START_IN)
    |=> O_RUN_CMD == SDOS_RC_STOP && !O_COAST_STOP)
    else $error("two-wire equal inputs did not stop");

  dir_both_a: assert property (
    s_dir_mode ##0 (I_FWD_START_IN && I_REV_START_IN)
    |=> O_RUN_CMD == SDOS_RC_REV)
    else $error("start/dir mode both on not reverse");

  dir_stop_a: assert property (
    s_dir_mode ##0 !I_FWD_START_IN |=> O_RUN_CMD == SDOS_RC_STOP)
    else $error("start/dir mode without start not stopped");

  init_sel_a: assert property (
    $rose(I_RST_N) |-> O_OUT0_FUNC_SELECT == SEL_INIT_OC0 &&
    O_OUT1_FUNC_SELECT == SEL_INIT_OC1 &&
    O_RELAY_FUNC_SELECT == SEL_INIT_RELAY)
    else $error("selectors not at initial codes");

  neg_pol_a: assert property (
    s_oc0_hold(SEL_NEG_OFS) ##0 (I_POS_CTRL && I_OP_READY2)
    |=> !O_OUT0)
    else $error("inverted running code not inverted");

  relay_93_a: assert property (
    I_RELAY_SEL_WR && sdos_base(I_RELAY_FUNC_SELECT) == C_OC_ONLY &&
    I_RELAY_FUNC_SELECT < SEL_NEG_END
    |=> O_SEL_REJECT[2] && $stable(O_RELAY_FUNC_SELECT))
    else $error("relay selector took a collector-only code");

  oc_93_a: assert property (
    I_OUT0_SEL_WR && I_OUT0_FUNC_SELECT == 14'h005D
    |=> O_OUT0_FUNC_SELECT == 14'h005D && !O_SEL_REJECT[0])
    else $error("collector selector refused code 93");

  run_stop_a: assert property (
    s_oc0_hold(SEL_INIT_OC0) ##0 !I_POS_CTRL ##0
    (I_DECEL_STOP || I_ZERO_SPEED || I_SERVO_LOCK) |=> !O_OUT0)
    else $error("running stayed on after a stop event");

  run_pos_a: assert property (
    s_oc0_hold(SEL_INIT_OC0) ##0 I_POS_CTRL
    |=> O_OUT0 == $past(I_OP_READY2))
    else $error("running not following ready two");

  up_speed_a: assert property (
    s_oc1_hold(14'h0001) ##0 (!I_POS_CTRL && I_SPEED_REACHED)
    |=> O_OUT1)
    else $error("up-to-speed terminal late or missing");

  therm_trip_a: assert property (
    I_THERMAL_PCT >= THERM_TRIP_PCT |=> O_THERMAL_TRIP [*3])
    else $error("thermal trip not raised and held");

  cur_clear_a: assert property (
    I_CUR < I_CUR_LEVEL |=> st.cur_cnt == '0)
    else $error("current timer not cleared below level");

  bad_code_a: assert property (
    I_OUT1_SEL_WR && !sdos_code_ok(I_OUT1_FUNC_SELECT, 1'b0)
    |=> O_SEL_REJECT[1] && $stable(O_OUT1_FUNC_SELECT))
    else $error("illegal selector code accepted");

  none_code_a: assert property (
    s_oc1_hold(SEL_NONE) |=> !O_OUT1)
    else $error("unassigned terminal went active");

endmodule

// [hdl/sdos_pkg.sv]
// constants, types and decode functions of the start/output select block
package sdos_pkg;

  // ****************************************
  // widths and timing
  // ****************************************
  localparam int unsigned SEL_W = 14;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned TICK_W = 17;
  localparam int unsigned CLK_PERIOD_NS = 32'h0000_000A;
  localparam int unsigned TICK_PERIOD_NS = 32'h000F_4240;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ****************************************
  // stop selection setting values
  // ****************************************
  localparam logic [SEL_W-1:0] STOP_TIME_MAX = 14'h0064;
  localparam logic [SEL_W-1:0] STOP_DIR_MIN = 14'h03E8;
  localparam logic [SEL_W-1:0] STOP_DIR_MAX = 14'h044C;
  localparam logic [SEL_W-1:0] STOP_DEC_TWO = 14'h270F;
  localparam logic [SEL_W-1:0] STOP_DEC_DIR = 14'h22B8;

  // ****************************************
  // output function selector codes
  // ****************************************
  localparam logic [SEL_W-1:0] SEL_NEG_OFS = 14'h0064;
  localparam logic [SEL_W-1:0] SEL_NEG_END = 14'h00C8;
  localparam logic [SEL_W-1:0] SEL_NONE = 14'h270F;
  localparam logic [SEL_W-1:0] SEL_INIT_OC0 = 14'h0000;
  localparam logic [SEL_W-1:0] SEL_INIT_OC1 = 14'h0004;
  localparam logic [SEL_W-1:0] SEL_INIT_RELAY = 14'h0063;
  localparam logic [6:0] C_RUN = 7'h00;
  localparam logic [6:0] C_SU = 7'h01;
  localparam logic [6:0] C_OL = 7'h03;
  localparam logic [6:0] C_FU = 7'h04;
  localparam logic [6:0] C_RBP = 7'h07;
  localparam logic [6:0] C_THP = 7'h08;
  localparam logic [6:0] C_RY = 7'h0B;
  localparam logic [6:0] C_CUR = 7'h0C;
  localparam logic [6:0] C_ZERO = 7'h0D;
  localparam logic [6:0] C_RY2 = 7'h21;
  localparam logic [6:0] C_OC_ONLY = 7'h5D;
  localparam logic [6:0] C_FAULT = 7'h63;

  // ****************************************
  // percentages
  // ****************************************
  localparam logic [15:0] PCT_FULL = 16'h0064;
  localparam logic [15:0] REGEN_PRE_PCT = 16'h0055;
  localparam logic [7:0] THERM_TRIP_PCT = 8'h64;
  localparam logic [7:0] THERM_PRE_PCT = 8'h55;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic {SDOS_SM_TWO, SDOS_SM_DIR} sdos_stop_mode_t;
  typedef enum logic [1:0] {SDOS_RC_STOP, SDOS_RC_FWD, SDOS_RC_REV}
    sdos_run_cmd_t;

  typedef struct packed {
    logic running;
    logic up_to_speed;
    logic overload;
    logic speed_detect;
    logic regen_pre;
    logic thermal_pre;
    logic op_ready;
    logic op_ready2;
    logic cur_detect;
    logic zero_cur;
    logic oc_only;
    logic fault;
  } sdos_status_t;

  typedef struct packed {
    sdos_stop_mode_t stop_mode;
    logic coast;
    sdos_run_cmd_t run_cmd;
    logic run_flag;
    logic self_hold;
    logic therm_trip;
    logic [TICK_W-1:0] tick_cnt;
    logic [CNT_W-1:0] cur_cnt;
    logic [CNT_W-1:0] zero_cnt;
  } sdos_top_st_t;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic level;
    logic reject;
  } sdos_term_st_t;

  // ****************************************
  // selector decode
  // ****************************************
  function automatic logic [6:0] sdos_base(input logic [SEL_W-1:0] code);
    logic [SEL_W-1:0] b;
    b = (code >= SEL_NEG_OFS) ? code - SEL_NEG_OFS : code;
    return b[6:0];
  endfunction

  function automatic logic sdos_code_ok(input logic [SEL_W-1:0] code,
                                        input logic relay);
    logic ok;
    ok = 1'b0;
    if (code == SEL_NONE) begin
      ok = 1'b1;
    end else if (code < SEL_NEG_END) begin
      case (sdos_base(code))
        7'h00, 7'h01, 7'h03, 7'h04, 7'h07, 7'h08, 7'h0B, 7'h0C, 7'h0D,
        7'h0E, 7'h0F, 7'h10, 7'h15, 7'h18, 7'h19, 7'h1A, 7'h21, 7'h24,
        7'h26, 7'h2F, 7'h37, 7'h38, 7'h3C, 7'h3D, 7'h3F, 7'h40, 7'h44,
        7'h5A, 7'h5B, 7'h5F, 7'h60, 7'h62, 7'h63: ok = 1'b1;
        C_OC_ONLY: ok = ~relay;
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  function automatic logic sdos_pick(input logic [SEL_W-1:0] code,
                                     input sdos_status_t s);
    logic v;
    case (sdos_base(code))
      C_RUN: v = s.running;
      C_SU: v = s.up_to_speed;
      C_OL: v = s.overload;
      C_FU: v = s.speed_detect;
      C_RBP: v = s.regen_pre;
      C_THP: v = s.thermal_pre;
      C_RY: v = s.op_ready;
      C_CUR: v = s.cur_detect;
      C_ZERO: v = s.zero_cur;
      C_RY2: v = s.op_ready2;
      C_OC_ONLY: v = s.oc_only;
      C_FAULT: v = s.fault;
      default: v = 1'b0;
    endcase
    if (code == SEL_NONE) begin
      return 1'b0;
    end
    return (code >= SEL_NEG_OFS) ? ~v : v;
  endfunction

endpackage

// [hdl/sdos_term.sv]
// one output terminal: function selector register and polarity output
`timescale 1ns/1ns
module sdos_term
  import sdos_pkg::*;
#(
  parameter logic [SEL_W-1:0] P_INIT = SEL_INIT_OC0,
  parameter logic P_RELAY = 1'b0
)(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [SEL_W-1:0] i_code,
  input wire sdos_status_t i_status,
  output logic o_level,
  output logic [SEL_W-1:0] o_select,
  output logic o_reject
);

  sdos_term_st_t st;
  sdos_term_st_t next_st;

  // ****************************************
  // selector update and terminal drive
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.reject = 1'b0;
    if (i_wr) begin
      if (sdos_code_ok(i_code, P_RELAY)) begin
        next_st.sel = i_code;
      end else begin
        // refused code keeps old selection
        next_st.reject = 1'b1;
      end
    end
    next_st.level = sdos_pick(next_st.sel, i_status);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st.sel <= P_INIT;
      st.level <= 1'b0;
      st.reject <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_level = st.level;
  assign o_select = st.sel;
  assign o_reject = st.reject;

endmodule

// [sim/sdos_plc.sv]
// external controller model: start contacts and terminal sense inputs
`timescale 1ns/1ns
module sdos_plc (
  input wire logic i_mclk,
  input wire logic [1:0] i_cmd,
  input wire logic [2:0] i_term,
  output logic o_fwd,
  output logic o_rev,
  output logic [2:0] o_seen
);
  // ****************************************
  // contact card
  // ****************************************
  initial begin
    o_fwd = 1'b0;
    o_rev = 1'b0;
    o_seen = 3'h0;
  end
  // contacts follow the command one edge late, like a relay card
  always @(posedge i_mclk) begin
    o_fwd <= i_cmd[0];
    o_rev <= i_cmd[1];
    o_seen <= i_term;
  end
endmodule

// [sim/sdos_top_tb.sv]
// self-checking bench of the start decode and output select block
`timescale 1ns/1ns
module sdos_top_tb;
  import sdos_pkg::*;
  localparam int unsigned TK = 4;
  logic mclk, rst_n, pos, shr, idone, sbeg, dstop, zspd, slock, rdy2;
  logic reach, tlim, rrot, flt, aux, fwd, rev, coast, shen, trip;
  logic [1:0] cmd, runc;
  logic [2:0] wr, seen, rej;
  wire [2:0] term;
  logic [SEL_W-1:0] sset;
  logic [SEL_W-1:0] code [3];
  wire [SEL_W-1:0] sel [3];
  logic [15:0] spd, fth, rth, cur, clev, zlev, ctim, ztim;
  logic [7:0] duty, lim, therm;
  int bad_count, checks;

  sdos_plc sdos_plc_inst (.i_mclk(mclk), .i_cmd(cmd), .i_term(term),
    .o_fwd(fwd), .o_rev(rev), .o_seen(seen));

  sdos_top #(.P_TICK_CYCLES(TK)) sdos_top_inst (.I_MCLK(mclk),
    .I_RST_N(rst_n), .I_FWD_START_IN(fwd), .I_REV_START_IN(rev),
    .I_STOP_SELECT_SETTING(sset), .I_POS_CTRL(pos), .I_SELF_HOLD_REQ(shr),
    .I_OUT0_FUNC_SELECT(code[0]), .I_OUT0_SEL_WR(wr[0]),
    .I_OUT1_FUNC_SELECT(code[1]), .I_OUT1_SEL_WR(wr[1]),
    .I_RELAY_FUNC_SELECT(code[2]), .I_RELAY_SEL_WR(wr[2]),
    .I_INIT_DONE(idone), .I_START_BEGIN(sbeg), .I_DECEL_STOP(dstop),
    .I_ZERO_SPEED(zspd), .I_SERVO_LOCK(slock), .I_OP_READY2(rdy2),
    .I_SPEED_REACHED(reach), .I_TORQUE_LIMIT(tlim), .I_SPEED(spd),
    .I_REV_ROT(rrot), .I_FWD_THRESH(fth), .I_REV_THRESH(rth),
    .I_REGEN_DUTY(duty), .I_REGEN_LIMIT(lim), .I_THERMAL_PCT(therm),
    .I_CUR(cur), .I_CUR_LEVEL(clev), .I_CUR_TIME_MS(ctim),
    .I_ZERO_LEVEL(zlev), .I_ZERO_TIME_MS(ztim), .I_FAULT(flt),
    .I_AUX93(aux), .O_RUN_CMD(runc), .O_COAST_STOP(coast),
    .O_SELF_HOLD_EN(shen), .O_THERMAL_TRIP(trip), .O_OUT0(term[0]),
    .O_OUT1(term[1]), .O_RELAY_OUT(term[2]), .O_OUT0_FUNC_SELECT(sel[0]),
    .O_OUT1_FUNC_SELECT(sel[1]), .O_RELAY_FUNC_SELECT(sel[2]),
    .O_SEL_REJECT(rej));

  // ****************************************
  // expectations and helpers
  // ****************************************
  function automatic logic [1:0] exp_run(logic dm, logic f, logic r);
    if (f && !r) return 2'h1;
    if (dm) return (f && r) ? 2'h2 : 2'h0;
    return (r && !f) ? 2'h2 : 2'h0;
  endfunction

  function automatic logic exp_stat(int b);
    case (b)
      1: return reach && !pos;
      3: return tlim;
      4: return rrot ? spd >= rth : spd >= fth;
      7: return lim != 0 && duty * 100 >= lim * 85;
      8: return therm >= 85;
      11: return idone && !flt;
      33: return rdy2;
      93: return aux;
      default: return flt;
    endcase
  endfunction

  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wsel(int t, logic [SEL_W-1:0] c, logic ok);
    logic [SEL_W-1:0] old;
    old = sel[t];
    cyc(1);
    code[t] <= c;
    wr[t] <= 1'b1;
    cyc(1);
    wr[t] <= 1'b0;
    #1;
    chk("select", ok ? c : old, sel[t]);
    chk("reject", !ok, rej[t]);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    cyc(20000);
    bad_count++;
    end_of_test();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    int tbl [9];
    int sv [9];
    int b, t, inv;
    logic dm, cst;
    logic [1:0] c, r;
    tbl = '{1, 3, 4, 7, 8, 11, 33, 93, 99};
    sv = '{50, 1050, 9999, 500, 8888, 100, 1000, 1100, 0};
    rst_n = 1'b0;
    {pos, shr, idone, sbeg, dstop, zspd, slock, rdy2} = '0;
    {reach, tlim, rrot, flt, aux, cmd, wr} = '0;
    {spd, fth, rth, cur, clev, zlev, ctim, ztim, duty, lim, therm} = '0;
    sset = 14'h270F;
    code = '{14'h0000, 14'h0000, 14'h0000};
    dm = 1'b0;
    cst = 1'b0;
    void'($urandom(1029));
    cyc(19);
    #1;
    chk("sel0 reset", 16'h0000, sel[0]);
    chk("sel1 reset", 16'h0004, sel[1]);
    chk("relay reset", 16'h0063, sel[2]);
    chk("run reset", 16'h0000, runc);
    cyc(1);
    rst_n <= 1'b1;
    wsel(2, 14'h005D, 1'b0);
    wsel(2, 14'h00C1, 1'b0);
    wsel(0, 14'h005D, 1'b1);
    wsel(1, 14'h00C1, 1'b1);
    wsel(1, 14'h00FA, 1'b0);
    wsel(0, 14'h0002, 1'b0);
    wsel(2, 14'h270F, 1'b1);
    wsel(1, 14'h270F, 1'b1);
    cyc(1);
    flt <= 1'b1;
    cyc(3);
    #1;
    chk("relay none", 16'h0000, term[2]);
    chk("out1 none", 16'h0000, term[1]);
    for (int i = 0; i < 36; i++) begin
      b = tbl[i % 9];
      t = $urandom % 3;
      if (b == 93 && t == 2) t = 0;
      inv = $urandom % 2;
      wsel(t, 14'(b + 100 * inv), 1'b1);
      for (int k = 0; k < 3; k++) begin
        cyc(1);
        {reach, tlim, rrot, flt, aux, idone, rdy2} <= 7'($urandom);
        spd <= 16'($urandom % 256);
        fth <= 16'($urandom % 256);
        rth <= 16'($urandom % 256);
        duty <= 8'($urandom % 200);
        lim <= 8'($urandom % 100);
        therm <= 8'($urandom % 100);
        cyc(3);
        #1;
        chk("terminal", exp_stat(b) ^ inv, term[t]);
      end
    end
    cyc(1);
    {reach, tlim, rrot, flt, aux, idone, rdy2, therm} <= '0;
    for (int s = 0; s < 9; s++) begin
      if (sv[s] != 500) dm = sv[s] >= 1000 && sv[s] != 9999;
      if (sv[s] != 500) cst = sv[s] <= 100 || (sv[s] >= 1000 && sv[s] <= 1100);
      r = 2'($urandom);
      cyc(1);
      sset <= 14'(sv[s]);
      for (int k = 0; k < 4; k++) begin
        c = 2'(k) ^ r;
        cyc(1);
        cmd <= c;
        shr <= 1'($urandom);
        pos <= 1'($urandom);
        cyc(4);
        #1;
        chk("run cmd", exp_run(dm, c[0], c[1]), runc);
        chk("coast", cst, coast);
        chk("self hold", shr && !pos, shen);
      end
    end
    cyc(1);
    {cmd, pos, shr} <= '0;
    sset <= 14'h270F;
    wsel(0, 14'h0000, 1'b1);
    wsel(1, 14'h000B, 1'b1);
    for (int k = 0; k < 3; k++) begin
      cyc(1);
      cmd <= 2'h1;
      cyc(3);
      sbeg <= 1'b1;
      cyc(1);
      sbeg <= 1'b0;
      cyc(2);
      #1;
      chk("running", 16'h0001, term[0]);
      chk("ready run", 16'h0001, term[1]);
      cyc(1);
      dstop <= k == 0;
      zspd <= k == 1;
      slock <= k == 2;
      cyc(1);
      {dstop, zspd, slock} <= '0;
      cyc(2);
      #1;
      chk("stopped", 16'h0000, term[0]);
    end
    cyc(1);
    pos <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wsel(0, 14'(100 * (k / 2)), 1'b1);
      cyc(1);
      rdy2 <= 1'(k % 2);
      cyc(3);
      #1;
      chk("pos running", 16'((k % 2) ^ (k / 2)), term[0]);
    end
    cyc(1);
    {pos, rdy2, cmd} <= '0;
    clev <= 16'h0190;
    zlev <= 16'h00C8;
    ctim <= 16'h0002;
    ztim <= 16'h0002;
    cur <= 16'h012C;
    for (int i = 0; i < 2; i++) begin
      wsel(i, 14'(12 + i), 1'b1);
      cyc(1);
      cur <= i ? 16'h0064 : 16'h01F4;
      cyc(4);
      #1;
      chk("detect early", 16'h0000, term[i]);
      cyc(40);
      #1;
      chk("detect late", 16'h0001, term[i]);
      cyc(1);
      cur <= 16'h012C;
      cyc(3);
      #1;
      chk("detect drop", 16'h0000, term[i]);
    end
    wsel(1, 14'h0008, 1'b1);
    for (int k = 0; k < 2; k++) begin
      cyc(1);
      therm <= 8'h54 + 8'(k);
      cyc(3);
      #1;
      chk("thermal pre", 16'(k), term[1]);
    end
    wsel(2, 14'h0063, 1'b1);
    cyc(1);
    therm <= 8'h64;
    cyc(3);
    #1;
    chk("trip", 16'h0001, trip);
    chk("relay fault", 16'h0001, term[2]);
    cyc(1);
    therm <= 8'h00;
    cyc(3);
    #1;
    chk("trip held", 16'h0001, trip);
    chk("controller sees relay", 16'h0001, seen[2]);
    end_of_test();
  end
endmodule
